//--- ncc_pkg.sv
// Constants, opcodes and state type of the nibble core control.
// Assumes one 200 MHz clock; instruction encoding is local to this core.
package ncc_pkg;
  // Timing
  localparam int          CYCLE_CLOCKS = 16;
  localparam logic [3:0]  CYC_LAST     = 4'(CYCLE_CLOCKS - 1);
  // Vectors and program space
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] CONV_VECTOR  = 12'h001;
  localparam logic [11:0] TIMER_VECTOR = 12'h002;
  localparam logic [11:0] PIN_VECTOR   = 12'h004;
  localparam logic [11:0] ROM_LAST     = 12'h3FF;
  // Data space
  localparam logic [6:0]  ADDR_IE       = 7'h00;
  localparam logic [6:0]  ADDR_IRQ      = 7'h01;
  localparam logic [6:0]  ADDR_TBR      = 7'h0E;
  localparam logic [6:0]  ADDR_INDIRECT = 7'h0F;
  localparam logic [6:0]  ADDR_PTR_LO   = 7'h10;
  localparam logic [6:0]  ADDR_PTR_MID  = 7'h11;
  localparam logic [6:0]  ADDR_PTR_HI   = 7'h12;
  localparam logic [6:0]  DMEM_FIRST    = 7'h20;
  localparam logic [6:0]  DMEM_LAST     = 7'h7F;
  localparam int          DMEM_WORDS    = 128;
  // Interrupt flag layout
  localparam int          BIT_CONV   = 3;
  localparam int          BIT_TIMER  = 2;
  localparam int          BIT_PIN    = 0;
  localparam logic [3:0]  FLAG_MASK  = 4'hD;
  localparam logic [3:0]  FLAG_RESET = 4'h0;
  // Stack
  localparam int          STACK_DEPTH = 4;
  localparam int          STACK_W     = 13;
  // Instruction classes, bits 15:14
  localparam logic [1:0]  CLS_REG = 2'h0, CLS_IMM = 2'h1, CLS_BR = 2'h2, CLS_CTL = 2'h3;
  // Register ops, bits 13:10
  localparam logic [3:0]  OP_ADC = 4'h0, OP_SBC = 4'h1, OP_ADD = 4'h2, OP_SUB = 4'h3;
  localparam logic [3:0]  OP_AND = 4'h4, OP_EOR = 4'h5, OP_OR = 4'h6, OP_DAA = 4'h7;
  localparam logic [3:0]  OP_DAS = 4'h8, OP_SHR = 4'h9, OP_LDA = 4'hA, OP_STA = 4'hB;
  // Immediate ops, bits 13:11
  localparam logic [2:0]  IM_ADI = 3'h0, IM_SBI = 3'h1, IM_AND = 3'h2, IM_EOR = 3'h3;
  localparam logic [2:0]  IM_OR  = 3'h4;
  // Control ops, bits 13:12, misc bits 11:10
  localparam logic [1:0]  CT_JMP = 2'h0, CT_CALL = 2'h1, CT_MISC = 2'h2, CT_HALT = 2'h3;
  localparam logic [1:0]  MS_TABLE_JUMP = 2'h0, MS_RETURN_WITH_CONSTANT = 2'h1, MS_RETURN_FROM_INTERRUPT = 2'h2;
  localparam logic [15:0] NOP_WORD = 16'hEC00;
  // Decimal adjust
  localparam logic [3:0]  BCD_LIMIT = 4'h9, BCD_FIX = 4'h6, BCD_FIX_SUB = 4'hA;
  // Core states, Gray along start, run, sleep
  typedef enum logic [1:0] {ST_START = 2'b00, ST_RUN = 2'b01, ST_SLEEP = 2'b11} ncc_state_t;
endpackage

//--- ncc_core.sv
// Control core of a 4-bit controller: PC, ALU, carry, stack, pointer, flags.
// Assumes a synchronous ROM answering within one instruction cycle and
// peripheral event pulses on the same clock.
// Operation
// - Twelve-bit program counter: page bit on top, eleven-bit incrementer below.
// - Unconditional jump loads the page bit too, reaching above 2K.
// - Program counter addresses at most 4K words.
// - Carry takes the carry or borrow of each arithmetic operation.
// - Call and interrupt push carry; interrupt return restores it; constant return not.
// - ALU: add, subtract, decimal adjust, logic, branches on bits, zero, carry, shift.
// - Four-bit accumulator holds results; moves to and from registers and memory.
// - Table jump goes to PC upper four bits, table nibble, accumulator.
// - Constant return loads word bits 7-4 to table nibble, 3-0 to accumulator.
// - Pointer is high three, middle three and low four bits, ten total.
// - Indirect window reads and writes memory addressed by the pointer.
// - Stack holds four 13-bit entries, carry on top; pushes, pops last-first.
// - A fifth nesting level silently drops the oldest entry.
// - Memory and registers keep their contents while the core sleeps.
// - Registers at 000-01F, data memory at 020-07F, directly addressable.
// - Program memory is 1024 words of 16 bits at 000-3FF.
// - Vectors: reset 000, converter 001, timer 002, pin 004; 003 unused.
// - Enable flags: converter bit 3, timer bit 2, pin bit 0.
// - Request flags at 01, same bits, readable and writable.
// - One instruction takes sixteen clock periods.
// - Reset starts the program counter at 000.
// - Enabled pending request pushes PC and carry, vectors, clears all enables.
// - Reset clears enable and request flags.
`timescale 1ns/100ps
module ncc_core (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Program memory
  output logic [11:0]               rom_addr,
  input  wire logic [15:0]          rom_data,
  // Peripheral events, one-cycle pulses
  input  wire logic                 conv_event,
  input  wire logic                 timer_event,
  input  wire logic                 pin_event,
  // Core state
  output logic [3:0]                accumulator_nibble,
  output logic                      carry_flag,
  output logic                      core_asleep
);
  import ncc_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  ncc_state_t          state_reg;
  logic [3:0]          div_reg;
  logic                cyc_en;
  logic [11:0]         pc_reg;
  logic [3:0]          ac_reg;
  logic                cy_reg;
  logic [3:0]          ie_reg;
  logic [3:0]          irq_reg;
  logic [3:0]          tbr_reg;
  logic [3:0]          ptr_lo_reg;
  logic [2:0]          ptr_mid_reg;
  logic [2:0]          ptr_hi_reg;
  logic [STACK_W-1:0]  stk_reg [0:STACK_DEPTH-1];
  logic [3:0]          dmem [0:DMEM_WORDS-1];
  logic [15:0]         instr;
  logic [9:0]          eff_addr;
  logic [3:0]          m;
  logic [3:0]          imm;
  logic [4:0]          sum;
  logic [3:0]          ac_next;
  logic                cy_next;
  logic [11:0]         pc_next;
  logic                push;
  logic                pop;
  logic [STACK_W-1:0]  push_val;
  logic                wr_en;
  logic [3:0]          wr_data;
  logic                tbr_load;
  logic                halt;
  logic                exec;
  logic                take_int;
  logic [3:0]          pend;
  logic [3:0]          taken;
  logic [11:0]         vec;
  logic                op_jmp;
  logic                op_table_jump;
  logic                op_return_with_constant;
  logic                op_return_from_interrupt;
  logic                op_step;
  logic                mem_we;
  logic                sys_we;

  // Memory range test, shared by the read and write paths
  function automatic logic in_dmem(input logic [9:0] a);
    return (a >= {3'h0, DMEM_FIRST}) && (a <= {3'h0, DMEM_LAST});
  endfunction

  // System register read decode; unmapped and unused bits read zero
  function automatic logic [3:0] sys_read(input logic [6:0] a);
    if (a == ADDR_IE) return ie_reg;
    else if (a == ADDR_IRQ) return irq_reg;
    else if (a == ADDR_TBR) return tbr_reg;
    else if (a == ADDR_PTR_LO) return ptr_lo_reg;
    else if (a == ADDR_PTR_MID) return {1'b0, ptr_mid_reg};
    else if (a == ADDR_PTR_HI) return {1'b0, ptr_hi_reg};
    else return 4'h0;
  endfunction

  // Instruction cycle divider
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 4'h0;
      cyc_en  <= 1'b0;
    end else begin
      div_reg <= (div_reg == CYC_LAST) ? 4'h0 : div_reg + 4'h1;
      cyc_en  <= (div_reg == CYC_LAST);
    end
  end

  assign exec = cyc_en && (state_reg == ST_RUN);

  // Interrupt arbitration, lowest vector first
  always_comb begin
    pend  = ie_reg & irq_reg;
    vec   = PIN_VECTOR;
    taken = 4'h0;
    if (pend[BIT_CONV]) begin
      vec = CONV_VECTOR;
      taken[BIT_CONV] = 1'b1;
    end else if (pend[BIT_TIMER]) begin
      vec = TIMER_VECTOR;
      taken[BIT_TIMER] = 1'b1;
    end else if (pend[BIT_PIN]) begin
      vec = PIN_VECTOR;
      taken[BIT_PIN] = 1'b1;
    end
    take_int = exec && (|pend);
    if (!take_int) taken = 4'h0;
  end

  // Fetch, operand access, ALU and sequencing
  always_comb begin
    instr    = (pc_reg > ROM_LAST) ? NOP_WORD : rom_data;
    imm      = instr[10:7];
    eff_addr = (instr[6:0] == ADDR_INDIRECT) ?
               {ptr_hi_reg, ptr_mid_reg, ptr_lo_reg} : {3'h0, instr[6:0]};
    if (in_dmem(eff_addr)) m = dmem[eff_addr[6:0]];
    else if (eff_addr < {3'h0, DMEM_FIRST}) m = sys_read(eff_addr[6:0]);
    else m = 4'h0;
    sum      = 5'h00;
    ac_next  = ac_reg;
    cy_next  = cy_reg;
    wr_en    = 1'b0;
    wr_data  = ac_reg;
    tbr_load = 1'b0;
    halt     = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    op_jmp   = 1'b0;
    op_table_jump  = 1'b0;
    op_return_with_constant  = 1'b0;
    op_return_from_interrupt  = 1'b0;
    op_step  = 1'b0;
    pc_next  = {pc_reg[11], pc_reg[10:0] + 11'h001};
    push_val = {cy_reg, pc_next};
    if (take_int) begin
      pc_next  = vec;
      push     = 1'b1;
      push_val = {cy_reg, pc_reg};
    end else begin
      case (instr[15:14])
        CLS_REG: begin
          op_step = 1'b1;
          case (instr[13:10])
            OP_ADC: sum = {1'b0, ac_reg} + {1'b0, m} + {4'h0, cy_reg};
            OP_SBC: sum = {1'b0, ac_reg} + {1'b0, ~m} + {4'h0, cy_reg};
            OP_ADD: sum = {1'b0, ac_reg} + {1'b0, m};
            OP_SUB: sum = {1'b0, ac_reg} + {1'b0, ~m} + 5'h01;
            default: sum = 5'h00;
          endcase
          case (instr[13:10])
            OP_ADC, OP_SBC, OP_ADD, OP_SUB: begin
              ac_next = sum[3:0];
              cy_next = sum[4];
            end
            OP_AND: ac_next = ac_reg & m;
            OP_EOR: ac_next = ac_reg ^ m;
            OP_OR:  ac_next = ac_reg | m;
            OP_DAA: if (ac_reg > BCD_LIMIT || cy_reg) begin
              ac_next = ac_reg + BCD_FIX;
              cy_next = 1'b1;
            end
            OP_DAS: if (ac_reg > BCD_LIMIT || !cy_reg) begin
              ac_next = ac_reg + BCD_FIX_SUB;
              cy_next = 1'b0;
            end
            OP_SHR: begin
              ac_next = {1'b0, ac_reg[3:1]};
              cy_next = ac_reg[0];
            end
            OP_LDA: ac_next = m;
            OP_STA: wr_en = 1'b1;
            default: ac_next = ac_reg;
          endcase
        end
        CLS_IMM: begin
          op_step = 1'b1;
          case (instr[13:11])
            IM_ADI: begin
              sum     = {1'b0, m} + {1'b0, imm};
              ac_next = sum[3:0];
              cy_next = sum[4];
            end
            IM_SBI: begin
              sum     = {1'b0, m} + {1'b0, ~imm} + 5'h01;
              ac_next = sum[3:0];
              cy_next = sum[4];
            end
            IM_AND: begin
              wr_en   = 1'b1;
              wr_data = m & imm;
            end
            IM_EOR: begin
              wr_en   = 1'b1;
              wr_data = m ^ imm;
            end
            IM_OR: begin
              wr_en   = 1'b1;
              wr_data = m | imm;
            end
            default: wr_en = 1'b0;
          endcase
        end
        CLS_BR: begin
          case (instr[13:11])
            3'h0, 3'h1, 3'h2, 3'h3: halt = ac_reg[instr[12:11]];
            3'h4: halt = (ac_reg == 4'h0);
            3'h5: halt = (ac_reg != 4'h0);
            3'h6: halt = cy_reg;
            default: halt = !cy_reg;
          endcase
          if (halt) pc_next = {pc_reg[11], instr[10:0]};
          else op_step = 1'b1;
          halt = 1'b0;
        end
        default: begin
          case (instr[13:12])
            CT_JMP: begin
              op_jmp  = 1'b1;
              pc_next = instr[11:0];
            end
            CT_CALL: begin
              push    = 1'b1;
              pc_next = {pc_reg[11], instr[10:0]};
            end
            CT_MISC: begin
              case (instr[11:10])
                MS_TABLE_JUMP: begin
                  op_table_jump = 1'b1;
                  pc_next = {pc_reg[11:8], tbr_reg, ac_reg};
                end
                MS_RETURN_WITH_CONSTANT: begin
                  op_return_with_constant  = 1'b1;
                  pop      = 1'b1;
                  pc_next  = stk_reg[0][11:0];
                  tbr_load = 1'b1;
                  ac_next  = instr[3:0];
                end
                MS_RETURN_FROM_INTERRUPT: begin
                  op_return_from_interrupt = 1'b1;
                  pop     = 1'b1;
                  pc_next = stk_reg[0][11:0];
                  cy_next = stk_reg[0][STACK_W-1];
                end
                default: op_step = 1'b1;
              endcase
            end
            default: begin
              halt    = 1'b1;
              op_step = 1'b1;
            end
          endcase
        end
      endcase
    end
    mem_we = exec && !take_int && wr_en && in_dmem(eff_addr);
    sys_we = exec && !take_int && wr_en && (eff_addr < {3'h0, DMEM_FIRST});
  end

  // Core state; top state bit marks sleep
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state_reg <= ST_START;
    else if (cyc_en) begin
      case (state_reg)
        ST_START: state_reg <= ST_RUN;
        ST_RUN:   if (!take_int && halt) state_reg <= ST_SLEEP;
        ST_SLEEP: if (|irq_reg) state_reg <= ST_RUN;
        default:  state_reg <= ST_START;
      endcase
    end
  end

  // Program counter and stack
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= RESET_VECTOR;
      for (int i = 0; i < STACK_DEPTH; i++) stk_reg[i] <= '0;
    end else if (exec) begin
      pc_reg <= pc_next;
      if (push) begin
        stk_reg[0] <= push_val;
        for (int i = 1; i < STACK_DEPTH; i++) stk_reg[i] <= stk_reg[i-1];
      end else if (pop) begin
        for (int i = 0; i < STACK_DEPTH - 1; i++) stk_reg[i] <= stk_reg[i+1];
      end
    end
  end

  // Accumulator and carry
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ac_reg <= 4'h0;
      cy_reg <= 1'b0;
    end else if (exec && !take_int) begin
      ac_reg <= ac_next;
      cy_reg <= cy_next;
    end
  end

  // Interrupt flags; hardware set wins over software clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ie_reg  <= FLAG_RESET;
      irq_reg <= FLAG_RESET;
    end else begin
      if (take_int) ie_reg <= FLAG_RESET;
      else if (sys_we && eff_addr[6:0] == ADDR_IE) ie_reg <= wr_data & FLAG_MASK;
      irq_reg <= (((sys_we && eff_addr[6:0] == ADDR_IRQ) ? wr_data : irq_reg) & ~taken
                  | {conv_event, timer_event, 1'b0, pin_event}) & FLAG_MASK;
    end
  end

  // Table nibble and pointer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tbr_reg     <= 4'h0;
      ptr_lo_reg  <= 4'h0;
      ptr_mid_reg <= 3'h0;
      ptr_hi_reg  <= 3'h0;
    end else if (exec && !take_int) begin
      if (tbr_load) tbr_reg <= instr[7:4];
      else if (sys_we && eff_addr[6:0] == ADDR_TBR) tbr_reg <= wr_data;
      if (sys_we && eff_addr[6:0] == ADDR_PTR_LO) ptr_lo_reg <= wr_data;
      if (sys_we && eff_addr[6:0] == ADDR_PTR_MID) ptr_mid_reg <= wr_data[2:0];
      if (sys_we && eff_addr[6:0] == ADDR_PTR_HI) ptr_hi_reg <= wr_data[2:0];
    end
  end

  // Data memory, no reset, kept through sleep
  always_ff @(posedge clock) begin
    if (mem_we) dmem[eff_addr[6:0]] <= wr_data;
  end

  assign rom_addr           = pc_reg;
  assign accumulator_nibble = ac_reg;
  assign carry_flag         = cy_reg;
  assign core_asleep        = state_reg[1];

  // Checks
  chk_cycle_gap: assert property (cyc_en |=> !cyc_en [*8] ##1 !cyc_en [*7] ##1 cyc_en)
    else $error("instruction cycle not sixteen clocks");
  chk_reset_state: assert property ($rose(rst_b) |-> rom_addr == RESET_VECTOR && ie_reg == 4'h0
    && irq_reg == 4'h0)
    else $error("reset state wrong");
  chk_pc_step: assert property (exec && !take_int && op_step |=> rom_addr[10:0] ==
    $past(pc_reg[10:0]) + 11'h001 && rom_addr[11] == $past(pc_reg[11]))
    else $error("pc did not step within page");
  chk_jump_page: assert property (exec && !take_int && op_jmp |=> rom_addr == $past(instr[11:0]))
    else $error("jump target wrong");
  chk_table_jump: assert property (exec && !take_int && op_table_jump |=>
    rom_addr == {$past(pc_reg[11:8]), $past(tbr_reg), $past(ac_reg)})
    else $error("table jump target wrong");
  chk_const_ret: assert property (exec && !take_int && op_return_with_constant |=> tbr_reg == $past(instr[7:4])
    && ac_reg == $past(instr[3:0]) && cy_reg == $past(cy_reg)
    && rom_addr == $past(stk_reg[0][11:0]))
    else $error("constant return wrong");
  chk_int_return: assert property (exec && !take_int && op_return_from_interrupt |=>
    {cy_reg, rom_addr} == $past(stk_reg[0]))
    else $error("interrupt return did not restore");
  chk_int_entry: assert property (take_int |=> ie_reg == 4'h0 && stk_reg[0] ==
    $past({cy_reg, pc_reg}) && stk_reg[1] == $past(stk_reg[0]))
    else $error("interrupt entry wrong");
  chk_int_priority: assert property (take_int && pend[BIT_CONV] && pend[BIT_PIN] |=>
    rom_addr == CONV_VECTOR && irq_reg[BIT_PIN])
    else $error("priority or pending flag wrong");
  chk_event_wins: assert property (timer_event |=> irq_reg[BIT_TIMER] ##15 state_reg != ST_START)
    else $error("request event lost");
  chk_unused_bits: assert property (exec && sys_we |=> ie_reg[1] == 1'b0 && irq_reg[1] == 1'b0)
    else $error("unused flag bit set");
  cov_interrupt: cover property (take_int ##16 (exec && op_return_from_interrupt));
  cov_table_jump: cover property (exec && !take_int && op_table_jump);
  cov_const_ret: cover property (exec && !take_int && op_return_with_constant);
  cov_sleep_wake: cover property ($rose(core_asleep) ##[1:1000] $fell(core_asleep));
endmodule // ncc_core

//--- test_nibble_cpu_core_control.sv
// Self-checking bench for the nibble core: plays program memory, pulses events,
// and checks PC, accumulator, carry and sleep at the ports.
// Assumes ncc_pkg and ncc_core are compiled first.
`timescale 1ns/100ps
module test_nibble_cpu_core_control;
  import ncc_pkg::*;
  // Design ports
  logic        clock;
  logic        rst_b;
  logic [11:0] rom_addr;
  logic [15:0] rom_data;
  logic        conv_event;
  logic        timer_event;
  logic        pin_event;
  logic [3:0]  accumulator_nibble;
  logic        carry_flag;
  logic        core_asleep;
  // Bench state
  int          error_cnt;
  int          checks_done;
  logic [31:0] seed;
  logic [11:0] pc;
  logic        cy;
  logic [3:0]  acc;

  ncc_core uut (
    .clock              (clock),
    .rst_b              (rst_b),
    .rom_addr           (rom_addr),
    .rom_data           (rom_data),
    .conv_event         (conv_event),
    .timer_event        (timer_event),
    .pin_event          (pin_event),
    .accumulator_nibble (accumulator_nibble),
    .carry_flag         (carry_flag),
    .core_asleep        (core_asleep)
  );

  // 200 MHz clock
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  // Repeatable random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Instruction encoders
  function automatic logic [15:0] rop(logic [3:0] op, logic [6:0] a);
    return {CLS_REG, op, 3'h0, a};
  endfunction
  function automatic logic [15:0] iop(logic [2:0] op, logic [3:0] im, logic [6:0] a);
    return {CLS_IMM, op, im, a};
  endfunction
  function automatic logic [15:0] ctl(logic [1:0] ct, logic [11:0] f);
    return {CLS_CTL, ct, f};
  endfunction

  // Expected {carry, accumulator} of a register operation
  function automatic logic [4:0] alu(logic [3:0] op, logic [3:0] a, logic [3:0] m, logic c);
    case (op)
      OP_ADC: return {1'h0, a} + {1'h0, m} + 5'(c);
      OP_ADD: return {1'h0, a} + {1'h0, m};
      OP_SBC: return {1'h0, a} + {1'h0, ~m} + 5'(c);
      OP_SUB: return {1'h0, a} + {1'h0, ~m} + 5'h01;
      OP_AND: return {c, a & m};
      OP_EOR: return {c, a ^ m};
      OP_DAA: return (a > BCD_LIMIT || c) ? {1'h1, a + BCD_FIX} : {c, a};
      OP_DAS: return (a > BCD_LIMIT || !c) ? {1'h0, a + BCD_FIX_SUB} : {c, a};
      OP_SHR: return {a[0], 1'h0, a[3:1]};
      default: return {c, a | m};
    endcase
  endfunction

  // Expected branch decision
  function automatic logic taken(logic [2:0] c, logic [3:0] a, logic f);
    case (c)
      3'h4: return a == 4'h0;
      3'h5: return a != 4'h0;
      3'h6: return f;
      3'h7: return !f;
      default: return a[c[1:0]];
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One instruction slot, with optional event pulses in its first clock
  task automatic ex(input logic [15:0] w, input logic [11:0] nxt, input logic [2:0] ev);
    rom_data = w;
    {conv_event, timer_event, pin_event} = ev;
    @(negedge clock);
    {conv_event, timer_event, pin_event} = 3'h0;
    repeat (CYCLE_CLOCKS - 1) @(negedge clock);
    chk(16'(rom_addr), 16'(nxt));
    pc = nxt;
  endtask
  task automatic st(input logic [15:0] w);
    ex(w, pc + 12'h001, 3'h0);
  endtask
  task automatic ac();
    chk({11'h0, carry_flag, accumulator_nibble}, {11'h0, cy, acc});
  endtask
  task automatic setm(input logic [6:0] a, input logic [3:0] v);
    st(iop(IM_AND, 4'h0, a));
    st(iop(IM_OR, v, a));
  endtask
  // Align to the word at 001, once the word at 000 has executed after reset
  task automatic sync();
    int n;
    n = 0;
    rom_data = NOP_WORD;
    while (rom_addr === 12'h000 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk(16'(rom_addr), 16'h0001);
    pc = 12'h001;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [3:0]  a, b, v, op;
    logic [11:0] rs [5];
    logic [11:0] ret;
    int          n;
    seed = 32'h3;
    error_cnt = 0;
    checks_done = 0;
    rst_b = 1'h0;
    rom_data = NOP_WORD;
    {conv_event, timer_event, pin_event} = 3'h0;
    repeat (10) @(negedge clock);
    chk(16'(rom_addr), 16'h0000);
    rst_b = 1'h1;
    sync();
    // Flag registers: reset value, unused bit
    st(rop(OP_LDA, ADDR_IRQ));
    chk(16'(accumulator_nibble), 16'h0000);
    st(iop(IM_OR, 4'hF, ADDR_IRQ));
    st(rop(OP_LDA, ADDR_IRQ));
    chk(16'(accumulator_nibble), 16'(FLAG_MASK));
    st(iop(IM_AND, 4'h0, ADDR_IRQ));
    st(iop(IM_OR, 4'hF, ADDR_IE));
    st(rop(OP_LDA, ADDR_IE));
    chk(16'(accumulator_nibble), 16'(FLAG_MASK));
    st(iop(IM_AND, 4'h0, ADDR_IE));
    setm(DMEM_FIRST, 4'h0);
    st(rop(OP_ADD, DMEM_FIRST));
    {cy, acc} = alu(OP_ADD, FLAG_MASK, 4'h0, 1'h0);
    ac();
    // Random arithmetic, logic and immediate operations
    for (int i = 0; i < 16; i++) begin
      a = 4'(xs());
      b = 4'(xs());
      op = 4'(xs() % 10);
      setm(DMEM_FIRST, a);
      setm(7'h21, b);
      st(rop(OP_LDA, DMEM_FIRST));
      st(rop(op, 7'h21));
      {cy, acc} = alu(op, a, b, cy);
      ac();
      st(iop(IM_ADI, b, DMEM_FIRST));
      {cy, acc} = alu(OP_ADD, a, b, cy);
      ac();
      st(iop(IM_SBI, b, DMEM_FIRST));
      {cy, acc} = alu(OP_SUB, a, b, cy);
      ac();
      st(iop(IM_EOR, b, DMEM_FIRST));
      st(rop(OP_LDA, DMEM_FIRST));
      acc = a ^ b;
      ac();
    end
    // Every branch condition, zero accumulator first
    for (int k = 0; k < 16; k++) begin
      v = (k < 8) ? 4'h0 : 4'(xs());
      setm(DMEM_FIRST, v);
      st(rop(OP_LDA, DMEM_FIRST));
      ex({CLS_BR, 3'(k), 11'h2A0}, taken(3'(k), v, cy) ? {pc[11], 11'h2A0} : pc + 12'h001,
         3'h0);
    end
    // Two simultaneous requests, carry saved and restored
    setm(DMEM_FIRST, 4'hF);
    st(rop(OP_LDA, DMEM_FIRST));
    st(rop(OP_ADD, DMEM_FIRST));
    {cy, acc} = alu(OP_ADD, 4'hF, 4'hF, cy);
    ac();
    st(iop(IM_OR, 4'hD, ADDR_IE));
    ret = pc;
    ex(NOP_WORD, CONV_VECTOR, 3'h5);
    st(rop(OP_LDA, ADDR_IE));
    chk(16'(accumulator_nibble), 16'h0000);
    st(rop(OP_LDA, ADDR_IRQ));
    chk(16'(accumulator_nibble), 16'h0001);
    st(rop(OP_SUB, DMEM_FIRST));
    ex(ctl(CT_MISC, {MS_RETURN_FROM_INTERRUPT, 10'h000}), ret, 3'h0);
    {cy, acc} = {1'h1, 4'h2};
    ac();
    st(iop(IM_OR, 4'h1, ADDR_IE));
    ret = pc;
    ex(NOP_WORD, PIN_VECTOR, 3'h0);
    ex(ctl(CT_MISC, {MS_RETURN_FROM_INTERRUPT, 10'h000}), ret, 3'h0);
    st(iop(IM_OR, 4'h4, ADDR_IE));
    ret = pc;
    ex(NOP_WORD, TIMER_VECTOR, 3'h2);
    ex(ctl(CT_MISC, {MS_RETURN_FROM_INTERRUPT, 10'h000}), ret, 3'h0);
    ac();
    // Five nested calls, four constant returns, then a table jump
    for (int i = 0; i < 5; i++) begin
      rs[i] = pc + 12'h001;
      ex(ctl(CT_CALL, {1'h0, 11'h100 + 11'(i * 16)}), {pc[11], 11'h100 + 11'(i * 16)},
         3'h0);
    end
    for (int i = 4; i > 0; i--) begin
      v = 4'(xs());
      ex(ctl(CT_MISC, {MS_RETURN_WITH_CONSTANT, 2'h0, 4'(i), v}), rs[i], 3'h0);
      acc = v;
      ac();
    end
    ex(ctl(CT_JMP, 12'h355), 12'h355, 3'h0);
    ex(ctl(CT_MISC, {MS_TABLE_JUMP, 10'h000}), {4'h3, 4'h1, acc}, 3'h0);
    // Pointer at the top of data memory, both directions
    setm(ADDR_PTR_LO, 4'hF);
    setm(ADDR_PTR_MID, 4'h7);
    setm(ADDR_PTR_HI, 4'h0);
    v = 4'(xs());
    setm(DMEM_LAST, v);
    st(rop(OP_LDA, ADDR_INDIRECT));
    acc = v;
    ac();
    st(iop(IM_EOR, 4'hF, ADDR_INDIRECT));
    st(rop(OP_LDA, DMEM_LAST));
    acc = ~v;
    ac();
    // Sleep, wake on a request, memory kept
    rom_data = ctl(CT_HALT, 12'h000);
    repeat (CYCLE_CLOCKS) @(negedge clock);
    chk(16'(core_asleep), 16'h0001);
    timer_event = 1'h1;
    @(negedge clock);
    timer_event = 1'h0;
    rom_data = rop(OP_LDA, DMEM_LAST);
    ret = rom_addr;
    n = 0;
    while (rom_addr === ret && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk(16'(core_asleep), 16'h0000);
    ac();
    ex(ctl(CT_JMP, 12'h200), 12'h200, 3'h0);
    // Upper page: no program memory there, leave by interrupt
    st(iop(IM_AND, 4'h0, ADDR_IRQ));
    st(iop(IM_OR, 4'h4, ADDR_IE));
    ex(ctl(CT_JMP, 12'hA55), 12'hA55, 3'h0);
    st(rop(OP_SHR, DMEM_FIRST));
    ac();
    ex(NOP_WORD, TIMER_VECTOR, 3'h2);
    st(iop(IM_OR, 4'hF, ADDR_IRQ));
    // Reset in mid-run
    rst_b = 1'h0;
    @(negedge clock);
    chk({rom_addr, 3'h0, core_asleep}, 16'h0000);
    rst_b = 1'h1;
    sync();
    st(rop(OP_LDA, ADDR_IRQ));
    chk(16'(accumulator_nibble), 16'h0000);
    end_of_test();
  end
endmodule // test_nibble_cpu_core_control
